// >>> emic_pkg.sv
package emic_pkg;

    // register byte addresses (printed offsets are multiples of two only,
    // so they are indexes; byte address is four times the index)
    localparam logic [15:0] REG_PAGE1_IDX  = 16'hC018;
    localparam logic [15:0] REG_PAGE2_IDX  = 16'hC01A;
    localparam logic [15:0] REG_UPPER_IDX  = 16'hC038;
    localparam logic [15:0] REG_TIMING_IDX = 16'hC03A;
    localparam logic [15:0] REG_MEMDIAG_IDX = 16'hC03E;
    localparam logic [17:0] ADDR_PAGE1   = {REG_PAGE1_IDX, 2'b00};
    localparam logic [17:0] ADDR_PAGE2   = {REG_PAGE2_IDX, 2'b00};
    localparam logic [17:0] ADDR_UPPER   = {REG_UPPER_IDX, 2'b00};
    localparam logic [17:0] ADDR_TIMING  = {REG_TIMING_IDX, 2'b00};
    localparam logic [17:0] ADDR_MEMDIAG = {REG_MEMDIAG_IDX, 2'b00};
    localparam logic [17:0] ADDR_STATUS  = 18'h30100;

    // reset values
    localparam logic [15:0] RST_PAGE    = 16'h0000;
    localparam logic [15:0] RST_UPPER   = 16'h0000;
    localparam logic [15:0] RST_TIMING  = 16'h0000;
    localparam logic [15:0] RST_MEMDIAG = 16'h0000;

    // field positions
    localparam int UPPER_EN_BIT  = 3;
    localparam int RAM_MERGE_BIT = 13;
    localparam int ROM_MERGE_BIT = 12;
    localparam int EXT_WIDTH_BIT = 11;
    localparam int EXT_WAIT_LSB  = 8;
    localparam int ROM_WIDTH_BIT = 7;
    localparam int ROM_WAIT_LSB  = 4;
    localparam int RAM_WIDTH_BIT = 3;
    localparam int RAM_WAIT_LSB  = 0;
    localparam int ARB_SEL_LSB   = 8;
    localparam int MONITOR_BIT   = 0;
    localparam int PAGE_EXT_BIT  = 8;

    // writable masks
    localparam logic [15:0] MASK_UPPER   = 16'h0008;
    localparam logic [15:0] MASK_TIMING  = 16'h3FFF;
    localparam logic [15:0] MASK_MEMDIAG = 16'h0701;

    // memory windows of the cpu address space
    localparam logic [15:0] WIN1_BASE = 16'h8000;
    localparam logic [15:0] WIN1_LAST = 16'h9FFF;
    localparam logic [15:0] WIN2_BASE = 16'hA000;
    localparam logic [15:0] WIN2_LAST = 16'hBFFF;
    localparam logic [15:0] ROM_BASE  = 16'hC100;
    localparam logic [15:0] ROM_LAST  = 16'hDFFF;
    localparam logic [15:0] RAM_BASE  = 16'h4000;
    localparam logic [15:0] RAM_LAST  = 16'h7FFF;

    // timing
    localparam int CPU_CLK_MHZ   = 48;
    localparam int REF_CLK_MHZ   = 125;
    localparam int MIN_STROBE    = 1;
    localparam logic [3:0] UPPER_PWRUP = 4'hF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STROBE = 2'b01,
        ST_DONE   = 2'b10
    } emic_state_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [15:0] addr;
    } emic_cpu_req_t;

    typedef struct packed {
        logic [18:0] addr;
        logic        extSelN;
        logic        ramSelN;
        logic        romSelN;
        logic        readN;
        logic        writeN;
        logic        byteMode;
    } emic_pins_t;

endpackage : emic_pkg

// >>> emic_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - arbitration code n blocks n of eight cycles
// - monitor bit echoes internal address onto pins
// - page map supplies address bits 28..13
// - window access drives pins 8..0 from page
// - SRAM mode drives only pins 4..0
// - page bit 21 zero selects extended space
// - upper enable frees pins 18..15 for addressing
// - upper pins driven high until configured
// - RAM merge asserts RAM select with extended
// - ROM merge asserts ROM select with extended
// - extended width bit picks eight or sixteen
// - extended wait states zero to seven
// - ROM width bit picks eight or sixteen
// - ROM wait states zero to seven
// - RAM width bit picks eight or sixteen
// - RAM wait states zero to seven
// - waits counted in 125 MHz reference clock cycles
// - diagnostic register write-only, resets zero
module emic_ctrl (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // axi4-lite write address
    input  wire logic [17:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [17:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // processor side
    input  wire emic_pkg::emic_cpu_req_t cpuReq,
    input  wire logic                  sramMode,
    output logic                       cpuAck,
    output logic                       memSlotFree,
    // external memory pins
    output emic_pkg::emic_pins_t       pins
);
    import emic_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] page1;
    logic [15:0] page2;
    logic [15:0] upper;
    logic [15:0] timing;
    logic [15:0] memDiag;
    logic        upperConfigured;
    emic_state_t state;

    logic        awHeld;
    logic        wHeld;
    logic [17:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        doWrite;
    logic        wrHit;
    logic [15:0] mergedData;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    always_comb begin
        unique case (awAddr)
            ADDR_PAGE1:   mergedData = page1;
            ADDR_PAGE2:   mergedData = page2;
            ADDR_UPPER:   mergedData = upper;
            ADDR_TIMING:  mergedData = timing;
            ADDR_MEMDIAG: mergedData = memDiag;
            default:      mergedData = 16'h0000;
        endcase
        if (wStrb[0]) begin
            mergedData[7:0] = wData[7:0];
        end
        if (wStrb[1]) begin
            mergedData[15:8] = wData[15:8];
        end
        wrHit = (awAddr == ADDR_PAGE1) || (awAddr == ADDR_PAGE2) ||
                (awAddr == ADDR_UPPER) || (awAddr == ADDR_TIMING) ||
                (awAddr == ADDR_MEMDIAG);
    end

    // write address and data accepted in either order
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 18'h00000;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !wHeld && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register storage; reserved bits are masked off
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            page1           <= RST_PAGE;
            page2           <= RST_PAGE;
            upper           <= RST_UPPER;
            timing          <= RST_TIMING;
            memDiag         <= RST_MEMDIAG;
            upperConfigured <= 1'b0;
        end else if (doWrite) begin
            unique case (awAddr)
                ADDR_PAGE1:   page1 <= mergedData;
                ADDR_PAGE2:   page2 <= mergedData;
                ADDR_UPPER: begin
                    upper           <= mergedData & MASK_UPPER;
                    upperConfigured <= 1'b1;
                end
                ADDR_TIMING:  timing <= mergedData & MASK_TIMING;
                ADDR_MEMDIAG: memDiag <= mergedData & MASK_MEMDIAG;
                default: begin
                end
            endcase
        end
    end

    // read channel; diagnostic register reads as zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_PAGE1:   s_axi_rdata <= {16'h0000, page1};
                    ADDR_PAGE2:   s_axi_rdata <= {16'h0000, page2};
                    ADDR_UPPER:   s_axi_rdata <= {16'h0000, upper};
                    ADDR_TIMING:  s_axi_rdata <= {16'h0000, timing};
                    ADDR_MEMDIAG: s_axi_rdata <= 32'h00000000;
                    ADDR_STATUS:  s_axi_rdata <= {28'h0000000,
                                        state == ST_STROBE, memSlotFree,
                                        upperConfigured,
                                        upper[UPPER_EN_BIT]};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration throttle
    logic [2:0] arbPhase;
    logic [2:0] arbSel;

    assign arbSel = memDiag[ARB_SEL_LSB +: 3];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            arbPhase    <= 3'h0;
            memSlotFree <= 1'b0;
        end else begin
            arbPhase    <= arbPhase + 3'h1;
            memSlotFree <= (arbPhase >= arbSel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access decode
    logic       inWin1;
    logic       inWin2;
    logic       inRom;
    logic       inRam;
    logic [15:0] pageReg;
    logic       extHit;
    logic [2:0] waitSel;
    logic       widthSel;

    always_comb begin
        inWin1  = cpuReq.addr >= WIN1_BASE && cpuReq.addr <= WIN1_LAST;
        inWin2  = cpuReq.addr >= WIN2_BASE && cpuReq.addr <= WIN2_LAST;
        inRom   = cpuReq.addr >= ROM_BASE && cpuReq.addr <= ROM_LAST;
        inRam   = cpuReq.addr >= RAM_BASE && cpuReq.addr <= RAM_LAST;
        pageReg = inWin2 ? page2 : page1;
        extHit  = (inWin1 || inWin2) && !pageReg[PAGE_EXT_BIT];
        if (extHit) begin
            waitSel  = timing[EXT_WAIT_LSB +: 3];
            widthSel = timing[EXT_WIDTH_BIT];
        end else if (inRom) begin
            waitSel  = timing[ROM_WAIT_LSB +: 3];
            widthSel = timing[ROM_WIDTH_BIT];
        end else begin
            waitSel  = timing[RAM_WAIT_LSB +: 3];
            widthSel = timing[RAM_WIDTH_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer, one step per reference clock
    logic [2:0]  waitCnt;
    logic [18:0] next_addr;
    logic        accExt;
    logic        accRom;
    logic        accRam;

    always_comb begin
        next_addr = {pins.addr[18:15], 6'h00, cpuReq.addr[8:0]};
        if (upper[UPPER_EN_BIT]) begin
            next_addr[18:15] = cpuReq.addr[15:12];
        end
        next_addr[14:9] = cpuReq.addr[14:9];
        if (inWin1 || inWin2) begin
            if (sramMode) begin
                next_addr[4:0] = pageReg[4:0];
            end else begin
                next_addr[8:0] = pageReg[8:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state   <= ST_IDLE;
            waitCnt <= 3'h0;
            cpuAck  <= 1'b0;
            accExt  <= 1'b0;
            accRom  <= 1'b0;
            accRam  <= 1'b0;
            pins    <= '{addr: {UPPER_PWRUP, 15'h0000},
                         extSelN: 1'b1, ramSelN: 1'b1, romSelN: 1'b1,
                         readN: 1'b1, writeN: 1'b1, byteMode: 1'b0};
        end else begin
            cpuAck <= 1'b0;
            if (memDiag[MONITOR_BIT] && state == ST_IDLE) begin
                pins.addr[15:0] <= cpuReq.addr;
            end
            if (!upperConfigured) begin
                pins.addr[18:15] <= UPPER_PWRUP;
            end else if (!upper[UPPER_EN_BIT]) begin
                pins.addr[18:15] <= 4'h0;
            end
            unique case (state)
                ST_IDLE: begin
                    if (cpuReq.req && memSlotFree &&
                        (extHit || inRom || inRam)) begin
                        state         <= ST_STROBE;
                        waitCnt       <= waitSel;
                        accExt        <= extHit;
                        accRom        <= inRom && !extHit;
                        accRam        <= inRam && !extHit;
                        pins.addr     <= next_addr;
                        pins.byteMode <= widthSel;
                        pins.extSelN  <= !extHit;
                        pins.romSelN  <= !(inRom ||
                            (extHit && timing[ROM_MERGE_BIT]));
                        pins.ramSelN  <= !(inRam ||
                            (extHit && timing[RAM_MERGE_BIT]));
                        pins.readN    <= cpuReq.write;
                        pins.writeN   <= !cpuReq.write;
                    end
                end
                ST_STROBE: begin
                    if (waitCnt == 3'h0) begin
                        state        <= ST_DONE;
                        pins.readN   <= 1'b1;
                        pins.writeN  <= 1'b1;
                        pins.extSelN <= 1'b1;
                        pins.romSelN <= 1'b1;
                        pins.ramSelN <= 1'b1;
                        cpuAck       <= 1'b1;
                    end else begin
                        waitCnt <= waitCnt - 3'h1;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : emic_ctrl

// >>> emic_ctrl_checker.sv
`timescale 1ns/100ps
module emic_ctrl_checker
    import emic_pkg::*;
(
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    resetn,
    // register writes
    input wire logic [17:0]             s_axi_awaddr,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic [31:0]             s_axi_wdata,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    // processor side
    input wire emic_pkg::emic_cpu_req_t cpuReq,
    input wire logic                    cpuAck,
    input wire logic                    memSlotFree,
    // external pins
    input wire emic_pkg::emic_pins_t    pins
);
    logic [15:0] tmg;
    logic [15:0] upr;
    logic        uprSet;
    logic [3:0]  lowCnt;
    logic [1:0]  selQ;
    logic [2:0]  expWait;
    logic        expByte;
    logic        strobe;
    assign strobe  = !(pins.readN && pins.writeN);
    assign expWait = !selQ[1] ? tmg[10:8] : !selQ[0] ? tmg[6:4] : tmg[2:0];
    assign expByte = !pins.extSelN ? tmg[11] : !pins.romSelN ? tmg[7] : tmg[3];
    ////////////////////////////////////////////////////////////////////////
    // shadow of the timing and upper registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tmg    <= RST_TIMING;
            upr    <= RST_UPPER;
            uprSet <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                     && s_axi_wready) begin
            if (s_axi_awaddr == ADDR_TIMING) begin
                tmg <= s_axi_wdata[15:0] & MASK_TIMING;
            end
            if (s_axi_awaddr == ADDR_UPPER) begin
                upr    <= s_axi_wdata[15:0];
                uprSet <= 1'b1;
            end
        end
    end
    // strobe length and space of the running access
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lowCnt <= 4'h0;
        end else if (strobe) begin
            lowCnt <= lowCnt + 4'h1;
            selQ   <= {pins.extSelN, pins.romSelN};
        end else begin
            lowCnt <= 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    a_slot_gap: assert property (
        $fell(memSlotFree) |-> ##[1:7] memSlotFree)
        else $error("free slot gap too long");
    a_take_slot: assert property (
        $rose(strobe) |-> $past(memSlotFree))
        else $error("access started in a dead slot");
    a_ack_end: assert property (
        $fell(strobe) |-> cpuAck ##1 !cpuAck)
        else $error("ack not a pulse at strobe end");
    a_wait_len: assert property (
        $fell(strobe) |-> lowCnt == {1'b0, expWait} + 4'h1)
        else $error("strobe length differs from wait setting");
    a_width_match: assert property (
        strobe |-> pins.byteMode == expByte)
        else $error("bus width differs from setting");
    a_ram_merge: assert property (
        strobe && tmg[RAM_MERGE_BIT] && !pins.extSelN |-> !pins.ramSelN)
        else $error("ram select not merged");
    a_rom_merge: assert property (
        strobe && tmg[ROM_MERGE_BIT] && !pins.extSelN |-> !pins.romSelN)
        else $error("rom select not merged");
    a_upper_high: assert property (
        !uprSet |-> pins.addr[18:15] == UPPER_PWRUP)
        else $error("upper lines not high before setup");
    a_upper_use: assert property (
        strobe && uprSet |-> pins.addr[18:15] ==
            (upr[UPPER_EN_BIT] ? cpuReq.addr[15:12] : 4'h0))
        else $error("upper lines wrong for enable");
endmodule : emic_ctrl_checker

bind emic_ctrl emic_ctrl_checker chk_u (.*);

// >>> emic_mem_model.sv
`timescale 1ns/100ps
module emic_mem_model
    import emic_pkg::*;
(
    // clock
    input  wire logic                 ref_clk,
    // external memory pins
    input  wire emic_pkg::emic_pins_t pins,
    // last access seen
    output emic_pkg::emic_pins_t      seen,
    output logic [7:0]                lowLen
);
    logic       strobe;
    logic [7:0] cnt = 8'h00;
    assign strobe = !(pins.readN && pins.writeN);
    // latch the pins as the strobe opens, time how long it stays low
    always @(posedge ref_clk) begin
        if (strobe && cnt == 8'h00) begin
            seen <= pins;
        end
        if (strobe) begin
            cnt <= cnt + 8'h01;
        end else if (cnt != 8'h00) begin
            lowLen <= cnt;
            cnt    <= 8'h00;
        end
    end
endmodule : emic_mem_model

// >>> emic_ctrl_test.sv
`timescale 1ns/100ps
module emic_ctrl_test;
    import emic_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, sramMode = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cpuAck, memSlotFree;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic [7:0]     lowLen;
    emic_cpu_req_t  cpuReq = 18'h00000;
    emic_pins_t     pins, seen;
    int n_mismatch = 0, cmp_count = 0;
    emic_ctrl dut_u (.*);
    emic_mem_model mem_u (.ref_clk(ref_clk), .pins(pins), .seen(seen),
                          .lowLen(lowLen));
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic axi_write(input logic [17:0] a, input logic [15:0] d,
                             input logic [1:0] er);
        logic aw = 1'b0, w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !(aw && w && s_axi_bvalid === 1'b1);
             n++) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        check("bvalid", 1'b1, s_axi_bvalid);
        check("bresp", er, s_axi_bresp);
        @(posedge ref_clk);
    endtask : axi_write
    task automatic axi_read(input logic [17:0] a, input logic [15:0] d,
                            input logic [1:0] er);
        logic ar = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !(ar && s_axi_rvalid === 1'b1); n++) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) begin
                ar = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        check("rvalid", 1'b1, s_axi_rvalid);
        check("rresp", er, s_axi_rresp);
        if (er == RESP_OKAY) check("rdata", d, s_axi_rdata[15:0]);
        @(posedge ref_clk);
    endtask : axi_read
    task automatic cpu_go(input logic [15:0] a, input logic wr);
        cpuReq <= {1'b1, wr, a};
        for (int n = 0; n < 100 && cpuAck !== 1'b1; n++) @(posedge ref_clk);
        cpuReq.req <= 1'b0;
        check("cpuAck", 1'b1, cpuAck);
        @(posedge ref_clk);
        check("strobes", {wr, ~wr}, {seen.readN, seen.writeN});
    endtask : cpu_go
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        check("upper at reset", UPPER_PWRUP, pins.addr[18:15]);
        axi_read(ADDR_PAGE1, RST_PAGE, RESP_OKAY);
        axi_read(ADDR_PAGE2, RST_PAGE, RESP_OKAY);
        axi_read(ADDR_UPPER, RST_UPPER, RESP_OKAY);
        axi_read(ADDR_TIMING, RST_TIMING, RESP_OKAY);
        axi_write(ADDR_MEMDIAG, 16'h0500, RESP_OKAY);
        axi_read(ADDR_MEMDIAG, RST_MEMDIAG, RESP_OKAY);
        axi_write(ADDR_MEMDIAG, 16'h0000, RESP_OKAY);
        axi_write(18'h00010, 16'h1234, RESP_SLVERR);
        axi_read(18'h00010, 16'h0000, RESP_SLVERR);
    endtask : t_regs
    task automatic t_upper();
        cpu_go(16'h7000, 1'b0);
        check("upper idle", UPPER_PWRUP, seen.addr[18:15]);
        axi_write(ADDR_UPPER, 16'h0008, RESP_OKAY);
        axi_read(ADDR_UPPER, 16'h0008, RESP_OKAY);
        cpu_go(16'h7000, 1'b1);
        check("upper on", 4'h7, seen.addr[18:15]);
        axi_write(ADDR_UPPER, 16'h0000, RESP_OKAY);
        cpu_go(16'h7000, 1'b0);
        check("upper off", 4'h0, seen.addr[18:15]);
    endtask : t_upper
    task automatic t_page();
        axi_write(ADDR_PAGE1, 16'h00B6, RESP_OKAY);
        axi_write(ADDR_PAGE2, 16'h0049, RESP_OKAY);
        axi_read(ADDR_PAGE1, 16'h00B6, RESP_OKAY);
        cpu_go(WIN1_BASE, 1'b0);
        check("page1 pins", 9'h0B6, seen.addr[8:0]);
        check("ext select", 1'b0, seen.extSelN);
        cpu_go(WIN2_LAST, 1'b1);
        check("page2 pins", 9'h049, seen.addr[8:0]);
        sramMode <= 1'b1;
        cpu_go(WIN1_LAST, 1'b0);
        check("sram pins", 5'h16, seen.addr[4:0]);
        sramMode <= 1'b0;
    endtask : t_page
    task automatic t_waits();
        logic [2:0]  w;
        logic [15:0] a [3];
        logic [2:0]  s [3];
        a = '{RAM_BASE, ROM_BASE, WIN1_BASE};
        s = '{3'h5, 3'h6, 3'h3};
        for (int i = 0; i < 3; i++) begin
            w = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'h5;
            axi_write(ADDR_TIMING, {4'h0, w[0], w, w[0], w, w[0], w},
                      RESP_OKAY);
            for (int j = 0; j < 3; j++) begin
                cpu_go(a[j], j[0]);
                check("selects", s[j],
                      {seen.extSelN, seen.ramSelN, seen.romSelN});
                check("strobe", w + 1, lowLen);
                check("byte mode", w[0], seen.byteMode);
            end
        end
    endtask : t_waits
    task automatic t_merge();
        for (int i = 1; i < 4; i++) begin
            axi_write(ADDR_TIMING, {2'b00, i[1:0], 12'h000}, RESP_OKAY);
            cpu_go(WIN2_BASE, 1'b0);
            check("merge", {1'b0, ~i[1], ~i[0]},
                  {seen.extSelN, seen.ramSelN, seen.romSelN});
        end
    endtask : t_merge
    task automatic t_throttle();
        logic [2:0] c;
        int k;
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'h3;
            axi_write(ADDR_MEMDIAG, {5'h00, c, 8'h00}, RESP_OKAY);
            repeat (4) @(posedge ref_clk);
            k = 0;
            repeat (16) begin
                @(posedge ref_clk);
                if (memSlotFree === 1'b1) k++;
            end
            check("free slots", 2 * (8 - c), k);
        end
        axi_write(ADDR_MEMDIAG, 16'h0001, RESP_OKAY);
        cpuReq.addr <= 16'h1234;
        repeat (2) @(posedge ref_clk);
        check("monitor", 15'h1234, pins.addr[14:0]);
        axi_write(ADDR_MEMDIAG, 16'h0000, RESP_OKAY);
    endtask : t_throttle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_upper();
        t_page();
        t_waits();
        t_merge();
        t_throttle();
        test_done();
    end
endmodule : emic_ctrl_test
